// *** tdc_opcode_pkg.sv ***
// constants, field layouts and carriers for the opcode handshake interpreter
package tdc_opcode_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] MICRO_IDX     = 16'h102E;
  localparam logic [15:0] HANDSHAKE_IDX = 16'h1030;
  localparam logic [15:0] STATUS_IDX    = 16'h1040;
  localparam int          ADDR_W        = 18;

  // handshake and status bit positions
  localparam int WP_BIT      = 0;
  localparam int RP_BIT      = 1;
  localparam int ST_BUSY     = 0;
  localparam int ST_UNKNOWN  = 1;
  localparam int ST_CHAN_OK  = 2;
  localparam int ST_CHIP_OK  = 3;
  localparam int ST_AUTOUSER = 4;

  // opcode word fields
  localparam int CMD_MSB = 15;
  localparam int CMD_LSB = 8;
  localparam int OBJ_MSB = 7;
  localparam int OBJ_LSB = 0;
  localparam int VAL_W   = 12;

  // command codes
  localparam logic [7:0] C_SELECT_WINDOW_MATCHING      = 8'h00;
  localparam logic [7:0] C_SELECT_FREE_RUNNING_STORAGE = 8'h01;
  localparam logic [7:0] C_QUERY_CAPTURE_MODE          = 8'h02;
  localparam logic [7:0] C_KEEP_TOKEN_ON               = 8'h03;
  localparam logic [7:0] C_KEEP_TOKEN_OFF              = 8'h04;
  localparam logic [7:0] C_RESTORE_FACTORY_SETUP       = 8'h05;
  localparam logic [7:0] C_STORE_CUSTOM_SETUP          = 8'h06;
  localparam logic [7:0] C_RESTORE_CUSTOM_SETUP        = 8'h07;
  localparam logic [7:0] C_BOOT_WITH_CUSTOM_SETUP      = 8'h08;
  localparam logic [7:0] C_BOOT_WITH_FACTORY_SETUP     = 8'h09;
  localparam logic [7:0] C_PROGRAM_WINDOW_SPAN         = 8'h10;
  localparam logic [7:0] C_PROGRAM_WINDOW_SHIFT        = 8'h11;
  localparam logic [7:0] C_PROGRAM_SEARCH_EXTENSION    = 8'h12;
  localparam logic [7:0] C_PROGRAM_DISCARD_MARGIN      = 8'h13;
  localparam logic [7:0] C_TURN_ON_TRIGGER_SUBTRACTION = 8'h14;
  localparam logic [7:0] C_TURN_OFF_TRIGGER_SUBTRACTION= 8'h15;
  localparam logic [7:0] C_QUERY_WINDOW_SETUP          = 8'h16;
  localparam logic [7:0] C_PROGRAM_EDGE_DETECT         = 8'h22;
  localparam logic [7:0] C_QUERY_EDGE_DETECT           = 8'h23;
  localparam logic [7:0] C_PROGRAM_EDGE_LSB            = 8'h24;
  localparam logic [7:0] C_PROGRAM_PAIR_RESOLUTION     = 8'h25;
  localparam logic [7:0] C_QUERY_RESOLUTION            = 8'h26;
  localparam logic [7:0] C_PROGRAM_DEAD_TIME           = 8'h28;
  localparam logic [7:0] C_QUERY_DEAD_TIME             = 8'h29;

  typedef struct packed {
    logic [2:0] n_write;
    logic [2:0] n_read;
    logic       setup_reload;
    logic       control_reload;
    logic       known;
  } dec_s;

  typedef struct packed {
    logic             window_match;
    logic             keep_token;
    logic             auto_reject;
    logic             trig_subtract;
    logic [VAL_W-1:0] window_span;
    logic [VAL_W-1:0] window_shift;
    logic [VAL_W-1:0] search_extension;
    logic [VAL_W-1:0] discard_margin;
    logic [1:0]       edge_detect;
    logic [1:0]       edge_lsb;
    logic [15:0]      pair_resolution;
    logic [1:0]       dead_time;
  } cfg_s;

  // factory setup; field values are plain defaults
  localparam cfg_s CFG_FACTORY = '{
    window_match:     1'b0,
    keep_token:       1'b0,
    auto_reject:      1'b0,
    trig_subtract:    1'b0,
    window_span:      12'h014,
    window_shift:     12'hFD8,
    search_extension: 12'h008,
    discard_margin:   12'h004,
    edge_detect:      2'h2,
    edge_lsb:         2'h2,
    pair_resolution:  16'h0000,
    dead_time:        2'h0
  };

endpackage : tdc_opcode_pkg

// *** opcode_table.sv ***
// opcode table: operand counts and reprogram flags per command
`timescale 1ns/1ps
module opcode_table (
  input  wire logic [7:0]          cmd,
  output tdc_opcode_pkg::dec_s     dec
);
  import tdc_opcode_pkg::*;

  function automatic dec_s lookup(input logic [7:0] c);
    dec_s d;
    d = '{n_write: 3'd0, n_read: 3'd0, setup_reload: 1'b0,
          control_reload: 1'b0, known: 1'b1};
    case (c)
      C_SELECT_WINDOW_MATCHING,
      C_SELECT_FREE_RUNNING_STORAGE,
      C_KEEP_TOKEN_ON,
      C_KEEP_TOKEN_OFF,
      // setup storage, reload ones touch setup
      C_RESTORE_FACTORY_SETUP,
      C_RESTORE_CUSTOM_SETUP,
      C_TURN_ON_TRIGGER_SUBTRACTION,
      C_TURN_OFF_TRIGGER_SUBTRACTION: d.setup_reload = 1'b1;
      C_STORE_CUSTOM_SETUP,
      C_BOOT_WITH_CUSTOM_SETUP,
      C_BOOT_WITH_FACTORY_SETUP: d.setup_reload = 1'b0;
      C_PROGRAM_WINDOW_SPAN,
      C_PROGRAM_WINDOW_SHIFT,
      C_PROGRAM_SEARCH_EXTENSION,
      C_PROGRAM_DISCARD_MARGIN,
      C_PROGRAM_EDGE_DETECT,
      C_PROGRAM_EDGE_LSB,
      C_PROGRAM_PAIR_RESOLUTION,
      C_PROGRAM_DEAD_TIME: begin
        d.n_write      = 3'd1;
        d.setup_reload = 1'b1;
      end
      C_QUERY_WINDOW_SETUP: d.n_read = 3'd5;
      C_QUERY_CAPTURE_MODE,
      C_QUERY_EDGE_DETECT,
      C_QUERY_RESOLUTION,
      C_QUERY_DEAD_TIME: d.n_read = 3'd1;
      // unlisted commands end at once; they change no setup, only the unknown flag and, through the object field, the range flags
      default: d.known = 1'b0;
    endcase
    return d;
  endfunction : lookup

  assign dec = lookup(cmd);

endmodule : opcode_table

// *** opcode_handshake_interpreter.sv ***
// command interpreter behind an apb slave: opcode word, operands, handshake flags
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module opcode_handshake_interpreter #(
  parameter int NUM_CHANNELS = 32
) (
  input  wire logic                          mclk,
  input  wire logic                          reset,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [tdc_opcode_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  output tdc_opcode_pkg::cfg_s               cfg,
  output logic                               setup_reload,
  output logic                               control_reload,
  output logic                               data_clear
);
  import tdc_opcode_pkg::*;

  typedef enum logic [2:0] {
    S_OPCODE, S_DECODE, S_TAKE, S_LOAD, S_GIVE, S_APPLY
  } state_e;

  localparam logic [ADDR_W-1:0] A_MICRO     = {MICRO_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] A_HANDSHAKE = {HANDSHAKE_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] A_STATUS    = {STATUS_IDX, 2'b00};

  state_e       state_q;
  logic         wp_q;
  logic         rp_q;
  logic [7:0]   cmd_q;
  logic [7:0]   obj_q;
  logic [15:0]  operand_q;
  logic [15:0]  word_q;
  logic [2:0]   left_q;
  logic [2:0]   idx_q;
  logic [2:0]   n_read_q;
  logic         unknown_q;
  logic         autouser_q;
  cfg_s         cfg_q;
  cfg_s         custom_q;
  logic         pready_q;
  logic [31:0]  prdata_q;
  logic         pslverr_q;
  logic         rd_ok_q;
  logic         setup_q;
  logic         control_q;
  logic         clear_q;
  dec_s         dec;

  opcode_table u_table (
    .cmd (cmd_q),
    .dec (dec)
  );

  function automatic logic obj_in_range(input logic [7:0] o, input int limit);
    return ({24'h0, o} < limit);
  endfunction : obj_in_range

  function automatic logic [15:0] result_word(input logic [7:0] c,
                                              input logic [2:0] i,
                                              input cfg_s f);
    logic [15:0] w;
    w = 16'h0000;
    case (c)
      C_QUERY_CAPTURE_MODE: w = {15'h0000, f.window_match};
      C_QUERY_EDGE_DETECT:  w = {14'h0000, f.edge_detect};
      C_QUERY_RESOLUTION:   w = f.pair_resolution;
      C_QUERY_DEAD_TIME:    w = {14'h0000, f.dead_time};
      C_QUERY_WINDOW_SETUP: begin
        case (i)
          3'd0:    w = {4'h0, f.window_span};
          3'd1:    w = {4'h0, f.window_shift};
          3'd2:    w = {4'h0, f.search_extension};
          3'd3:    w = {4'h0, f.discard_margin};
          default: w = {15'h0000, f.trig_subtract};
        endcase
      end
      default: w = 16'h0000;
    endcase
    return w;
  endfunction : result_word

  // bus decode; an access completes on the second access-phase edge
  wire        access    = psel & penable;
  wire        done      = access & pready_q;
  wire        hit_micro = (paddr == A_MICRO);
  wire        hit_hs    = (paddr == A_HANDSHAKE);
  wire        hit_stat  = (paddr == A_STATUS);
  wire        mapped    = hit_micro | hit_hs | hit_stat;
  wire        wr_micro  = done & pwrite & hit_micro & wp_q;
  // reads without permit return zero and change nothing
  // the permit seen when the data was captured decides, so a late permit loses no word
  wire        rd_micro  = done & ~pwrite & hit_micro & rd_ok_q;
  wire        busy      = (state_q != S_OPCODE);
  wire        chan_ok   = obj_in_range(obj_q, NUM_CHANNELS);
  wire        chip_ok   = obj_in_range(obj_q, NUM_CHANNELS / 8);
  wire [15:0] val_word  = {4'h0, operand_q[VAL_W-1:0]};

  wire [31:0] hs_word   = {30'h0, rp_q, wp_q};
  wire [31:0] stat_word = {27'h0, autouser_q, chip_ok, chan_ok, unknown_q, busy};
  wire [31:0] micro_rd  = rp_q ? {16'h0000, word_q} : 32'h0000_0000;
  wire [31:0] rd_mux    = hit_micro ? micro_rd :
                          hit_hs    ? hs_word  :
                          hit_stat  ? stat_word : 32'h0000_0000;

  // apb answer, registered so every output leaves a flip-flop
  always_ff @(posedge mclk) begin
    if (reset) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      rd_ok_q   <= 1'b0;
    end else begin
      pready_q  <= access & ~pready_q;
      prdata_q  <= (access & ~pready_q & ~pwrite) ? rd_mux : 32'h0000_0000;
      pslverr_q <= access & ~pready_q & ~mapped;
      rd_ok_q   <= access & ~pready_q & ~pwrite & hit_micro & rp_q;
    end
  end

  // interpreter sequence
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q   <= S_OPCODE;
      wp_q      <= 1'b1;
      rp_q      <= 1'b0;
      cmd_q     <= 8'h00;
      obj_q     <= 8'h00;
      operand_q <= 16'h0000;
      word_q    <= 16'h0000;
      left_q    <= 3'd0;
      idx_q     <= 3'd0;
      n_read_q  <= 3'd0;
      unknown_q <= 1'b0;
    end else begin
      case (state_q)
        S_OPCODE: begin
          if (wr_micro) begin
            cmd_q   <= pwdata[CMD_MSB:CMD_LSB];
            obj_q   <= pwdata[OBJ_MSB:OBJ_LSB];
            wp_q    <= 1'b0;
            state_q <= S_DECODE;
          end else begin
            wp_q <= 1'b1;
          end
        end
        S_DECODE: begin
          unknown_q <= ~dec.known;
          left_q    <= dec.n_write;
          n_read_q  <= dec.n_read;
          idx_q     <= 3'd0;
          if (dec.n_write != 3'd0) begin
            state_q <= S_TAKE;
          end else if (dec.n_read != 3'd0) begin
            state_q <= S_LOAD;
          end else begin
            state_q <= S_APPLY;
          end
        end
        S_TAKE: begin
          if (wr_micro) begin
            wp_q      <= 1'b0;
            operand_q <= pwdata[15:0];
            left_q    <= left_q - 3'd1;
            if (left_q == 3'd1) begin
              state_q <= (n_read_q != 3'd0) ? S_LOAD : S_APPLY;
            end
          end else begin
            // permit back once the next word fits
            wp_q <= 1'b1;
          end
        end
        S_LOAD: begin
          word_q  <= result_word(cmd_q, idx_q, cfg_q);
          // permit rises with a fresh word
          rp_q    <= 1'b1;
          state_q <= S_GIVE;
        end
        S_GIVE: begin
          // wait here until the word is read
          if (rd_micro) begin
            rp_q  <= 1'b0;
            idx_q <= idx_q + 3'd1;
            state_q <= (idx_q == n_read_q - 3'd1) ? S_APPLY : S_LOAD;
          end
        end
        S_APPLY: begin
          wp_q    <= 1'b1;
          state_q <= S_OPCODE;
        end
        default: begin
          state_q <= S_OPCODE;
          wp_q    <= 1'b1;
          rp_q    <= 1'b0;
        end
      endcase
    end
  end

  // configuration effects take hold when the exchange completes
  wire applying = (state_q == S_APPLY);

  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_q      <= CFG_FACTORY;
      custom_q   <= CFG_FACTORY;
      autouser_q <= 1'b0;
    end else if (applying) begin
      case (cmd_q)
        // matching turns on rejection and token keeping
        C_SELECT_WINDOW_MATCHING: begin
          cfg_q.window_match <= 1'b1;
          cfg_q.auto_reject  <= 1'b1;
          cfg_q.keep_token   <= 1'b1;
        end
        // free running turns off rejection and subtraction
        C_SELECT_FREE_RUNNING_STORAGE: begin
          cfg_q.window_match  <= 1'b0;
          cfg_q.auto_reject   <= 1'b0;
          cfg_q.trig_subtract <= 1'b0;
        end
        C_KEEP_TOKEN_ON:  cfg_q.keep_token <= 1'b1;
        C_KEEP_TOKEN_OFF: cfg_q.keep_token <= 1'b0;
        C_RESTORE_FACTORY_SETUP:   cfg_q      <= CFG_FACTORY;
        C_STORE_CUSTOM_SETUP:      custom_q   <= cfg_q;
        C_RESTORE_CUSTOM_SETUP:    cfg_q      <= custom_q;
        C_BOOT_WITH_CUSTOM_SETUP:  autouser_q <= 1'b1;
        C_BOOT_WITH_FACTORY_SETUP: autouser_q <= 1'b0;
        C_PROGRAM_WINDOW_SPAN:      cfg_q.window_span      <= val_word[VAL_W-1:0];
        C_PROGRAM_WINDOW_SHIFT:     cfg_q.window_shift     <= val_word[VAL_W-1:0];
        C_PROGRAM_SEARCH_EXTENSION: cfg_q.search_extension <= val_word[VAL_W-1:0];
        C_PROGRAM_DISCARD_MARGIN:   cfg_q.discard_margin   <= val_word[VAL_W-1:0];
        C_TURN_ON_TRIGGER_SUBTRACTION:  cfg_q.trig_subtract <= 1'b1;
        C_TURN_OFF_TRIGGER_SUBTRACTION: cfg_q.trig_subtract <= 1'b0;
        C_PROGRAM_EDGE_DETECT:     cfg_q.edge_detect     <= operand_q[1:0];
        C_PROGRAM_EDGE_LSB:        cfg_q.edge_lsb        <= operand_q[1:0];
        C_PROGRAM_PAIR_RESOLUTION: cfg_q.pair_resolution <= operand_q;
        C_PROGRAM_DEAD_TIME:       cfg_q.dead_time       <= operand_q[1:0];
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // reprogram pulses; setup reload also clears acquired data
  always_ff @(posedge mclk) begin
    if (reset) begin
      setup_q   <= 1'b0;
      control_q <= 1'b0;
      clear_q   <= 1'b0;
    end else begin
      setup_q   <= applying & dec.setup_reload;
      control_q <= applying & dec.control_reload;
      clear_q   <= applying & dec.setup_reload;
    end
  end

  assign pready         = pready_q;
  assign prdata         = prdata_q;
  assign pslverr        = pslverr_q;
  assign cfg            = cfg_q;
  assign setup_reload   = setup_q;
  assign control_reload = control_q;
  assign data_clear     = clear_q;

endmodule : opcode_handshake_interpreter

// *** opcode_handshake_interpreter_sva.sv ***
// bus and exchange assertions for the opcode interpreter
`timescale 1ns/1ps
module opcode_handshake_interpreter_sva (
  input wire logic                          mclk,
  input wire logic                          reset,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [tdc_opcode_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                   pwdata,
  input wire logic                          pready,
  input wire logic [31:0]                   prdata,
  input wire logic                          pslverr,
  input wire tdc_opcode_pkg::cfg_s          cfg,
  input wire logic                          setup_reload,
  input wire logic                          control_reload,
  input wire logic                          data_clear
);
  import tdc_opcode_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire mapped = (paddr == {MICRO_IDX, 2'b00}) || (paddr == {HANDSHAKE_IDX, 2'b00})
              || (paddr == {STATUS_IDX, 2'b00});
  answer_time_a: assert property ($rose(penable) && psel |=> pready)
    else $error("answer not on second access cycle");
  answer_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  answer_access_a: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside access phase");
  err_decode_a: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  idle_quiet_a: assert property (!pready |-> !pslverr && prdata == 32'h0000_0000)
    else $error("response outside answer cycle");
  word_width_a: assert property (pready && mapped |-> prdata[31:16] == 16'h0000)
    else $error("upper half not zero");
  clear_pair_a: assert property (setup_reload |-> data_clear ##1 !setup_reload && !data_clear)
    else $error("reload and clear not one paired pulse");
  clear_only_a: assert property (data_clear |-> setup_reload)
    else $error("clear without setup reload");
  no_control_a: assert property (!control_reload)
    else $error("control reload raised");
  cfg_reload_a: assert property ($changed(cfg) |-> setup_reload)
    else $error("setup change without reload");
endmodule : opcode_handshake_interpreter_sva
bind opcode_handshake_interpreter opcode_handshake_interpreter_sva chk (
  .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .cfg(cfg), .setup_reload(setup_reload), .control_reload(control_reload),
  .data_clear(data_clear));

// *** bus_master_model.sv ***
// apb master standing in for the programming host
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic                          mclk,
  input  wire logic                          pready,
  input  wire logic [31:0]                   prdata,
  input  wire logic                          pslverr,
  output logic                               psel,
  output logic                               penable,
  output logic                               pwrite,
  output logic [tdc_opcode_pkg::ADDR_W-1:0]  paddr,
  output logic [31:0]                        pwdata
);
  import tdc_opcode_pkg::*;
  int   hung = 0;
  int   slow = 0;
  logic err;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge mclk); while (pready !== 1'b1 && ++n < 50);
    q = prdata;
    err = pslverr;
    if (n >= 50) hung++;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines flip so stale values cannot pass
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
  task automatic poll(input int b);
    logic [31:0] h;
    int n;
    n = 0;
    do xfer(1'b0, {HANDSHAKE_IDX, 2'b00}, 32'h0000_0000, h); while (h[b] !== 1'b1 && ++n < 40);
    if (n >= 40) hung++;
  endtask : poll
  task automatic send(input logic [15:0] w);
    logic [31:0] q;
    repeat (slow) @(posedge mclk);
    poll(WP_BIT);
    xfer(1'b1, {MICRO_IDX, 2'b00}, {16'h0000, w}, q);
  endtask : send
  task automatic fetch(output logic [31:0] q);
    poll(RP_BIT);
    xfer(1'b0, {MICRO_IDX, 2'b00}, 32'h0000_0000, q);
  endtask : fetch
endmodule : bus_master_model

// *** test_opcode_handshake_interpreter.sv ***
// self-checking bench for the opcode interpreter
`timescale 1ns/1ps
module test_opcode_handshake_interpreter;
  import tdc_opcode_pkg::*;
  logic              mclk = 1'b0;
  logic              reset = 1'b1;
  logic              psel, penable, pwrite, pready, pslverr;
  logic              setup_reload, control_reload, data_clear;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, q;
  cfg_s              cfg, saved;
  cfg_s              exp_cfg = CFG_FACTORY;
  int                fails = 0;
  int                n_checks = 0;
  int                n_reload = 0;
  always #10 mclk = ~mclk;
  always @(posedge mclk) if (setup_reload === 1'b1) n_reload <= n_reload + 1;
  always @(posedge mclk) if (master.hung != 0) begin
    fails = fails + 1;
    summarize();
  end
  opcode_handshake_interpreter #(.NUM_CHANNELS(32)) dut (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cfg(cfg), .setup_reload(setup_reload), .control_reload(control_reload),
    .data_clear(data_clear));
  bus_master_model master (
    .mclk(mclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_cfg;
    n_checks++;
    if (cfg !== exp_cfg) begin
      fails++;
      $display("ERROR t=%0t cfg=%h exp=%h", $time, cfg, exp_cfg);
    end
  endtask : chk_cfg
  task automatic op(input logic [15:0] w, input int nw, input logic [15:0] d, input int rel);
    int r;
    r = n_reload;
    master.send(w);
    if (nw > 0) master.send(d);
    master.poll(WP_BIT);
    repeat (2) @(posedge mclk);
    chk(32'(n_reload - r), 32'(rel));
    chk_cfg();
  endtask : op
  task automatic query(input logic [15:0] w, input logic [31:0] exp);
    master.send(w);
    master.fetch(q);
    chk(q, exp);
  endtask : query
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    master.xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask : rd
  // idle flags, stray read, bad address
  task automatic t_reset;
    rd({HANDSHAKE_IDX, 2'b00}, 32'h0000_0001);
    rd({MICRO_IDX, 2'b00}, 32'h0000_0000);
    master.xfer(1'b1, {HANDSHAKE_IDX, 2'b00}, 32'h0000_0002, q);
    rd({HANDSHAKE_IDX, 2'b00}, 32'h0000_0001);
    master.xfer(1'b1, 18'h0_0010, 32'h0000_0005, q);
    chk({31'h0000_0000, master.err}, 32'h0000_0001);
    chk_cfg();
  endtask : t_reset
  task automatic t_window;
    logic [11:0] v;
    for (int i = 0; i < 4; i++) begin
      v = 12'h5A0 + 12'(i);
      case (i)
        0: exp_cfg.window_span = v;
        1: exp_cfg.window_shift = v;
        2: exp_cfg.search_extension = v;
        default: exp_cfg.discard_margin = v;
      endcase
      op({8'h10 + 8'(i), 8'hA5}, 1, {4'hF, v}, 1);
    end
  endtask : t_window
  task automatic t_query;
    master.slow = 3;
    exp_cfg.trig_subtract = 1'b1;
    op(16'h1400, 0, 16'h0000, 1);
    master.send(16'h1600);
    master.fetch(q);
    chk(q, {20'h0_0000, exp_cfg.window_span});
    master.fetch(q);
    chk(q, {20'h0_0000, exp_cfg.window_shift});
    master.fetch(q);
    chk(q, {20'h0_0000, exp_cfg.search_extension});
    master.fetch(q);
    chk(q, {20'h0_0000, exp_cfg.discard_margin});
    master.fetch(q);
    chk(q, 32'h0000_0001);
    rd({HANDSHAKE_IDX, 2'b00}, 32'h0000_0001);
    master.slow = 0;
    exp_cfg.trig_subtract = 1'b0;
    op(16'h1500, 0, 16'h0000, 1);
  endtask : t_query
  task automatic t_edge;
    exp_cfg.edge_detect = 2'h1;
    op(16'h2200, 1, 16'hFFF1, 1);
    query(16'h2300, 32'h0000_0001);
    exp_cfg.edge_lsb = 2'h3;
    op(16'h2400, 1, 16'h0003, 1);
    exp_cfg.pair_resolution = 16'hBEEF;
    op(16'h2500, 1, 16'hBEEF, 1);
    query(16'h2600, 32'h0000_BEEF);
    exp_cfg.dead_time = 2'h3;
    op(16'h2800, 1, 16'h0007, 1);
    query(16'h2900, 32'h0000_0003);
  endtask : t_edge
  task automatic t_mode;
    exp_cfg.window_match = 1'b1;
    exp_cfg.auto_reject = 1'b1;
    exp_cfg.keep_token = 1'b1;
    op(16'h0000, 0, 16'h0000, 1);
    query(16'h0200, 32'h0000_0001);
    exp_cfg.trig_subtract = 1'b1;
    op(16'h1400, 0, 16'h0000, 1);
    exp_cfg.window_match = 1'b0;
    exp_cfg.auto_reject = 1'b0;
    exp_cfg.trig_subtract = 1'b0;
    op(16'h0100, 0, 16'h0000, 1);
    query(16'h0200, 32'h0000_0000);
    exp_cfg.keep_token = 1'b0;
    op(16'h0400, 0, 16'h0000, 1);
    exp_cfg.keep_token = 1'b1;
    op(16'h0300, 0, 16'h0000, 1);
  endtask : t_mode
  task automatic t_config;
    saved = exp_cfg;
    op(16'h0600, 0, 16'h0000, 0);
    exp_cfg = CFG_FACTORY;
    op(16'h0500, 0, 16'h0000, 1);
    exp_cfg = saved;
    op(16'h0700, 0, 16'h0000, 1);
    op(16'h0800, 0, 16'h0000, 0);
    rd({STATUS_IDX, 2'b00}, 32'h0000_001C);
    op(16'h0900, 0, 16'h0000, 0);
    rd({STATUS_IDX, 2'b00}, 32'h0000_000C);
  endtask : t_config
  task automatic t_object;
    exp_cfg.trig_subtract = 1'b1;
    op(16'h141F, 0, 16'h0000, 1);
    rd({STATUS_IDX, 2'b00}, 32'h0000_0004);
    op(16'h1403, 0, 16'h0000, 1);
    rd({STATUS_IDX, 2'b00}, 32'h0000_000C);
    op(16'h1420, 0, 16'h0000, 1);
    rd({STATUS_IDX, 2'b00}, 32'h0000_0000);
    op(16'h7700, 0, 16'h0000, 0);
    rd({STATUS_IDX, 2'b00}, 32'h0000_000E);
  endtask : t_object
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_window();
    t_query();
    t_edge();
    t_mode();
    t_config();
    t_object();
    summarize();
  end
endmodule : test_opcode_handshake_interpreter
